// *** dv/tmrc_monitor.sv ***
// Purpose: Port assertions for the timer/counter.
// Assumes: One clock domain with synchronous reset.
// Notes:   Bound to every tmrc_top.
module tmrc_checker (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic       external_count_input,
	input wire logic [4:0] file_addr,
	input wire logic       file_wr,
	input wire logic [7:0] file_wdata,
	input wire logic       option_wr,
	input wire logic [7:0] option_wdata,
	input wire logic       watchdog_clear_op,
	input wire logic       wdt_tick_in,
	input wire logic [7:0] file_rdata,
	input wire logic [7:0] option_value,
	input wire logic       wdt_post_tick,
	input wire logic       timer_rollover,
	input wire logic       cycle_end
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	a_phase_ring: assert property (cycle_end |=> !cycle_end [*3] ##1 cycle_end)
		else $error("Phase ring is not four clocks.");
	a_option_load: assert property (option_wr |=> option_value == $past(option_wdata))
		else $error("Option write lost.");
	a_unmapped_zero: assert property (file_addr != 5'h01 |=> file_rdata == 8'h00)
		else $error("Unmapped read not zero.");
	a_write_hold: assert property ((file_wr && file_addr == 5'h01) ##1 (file_addr == 5'h01 && !file_wr) [*6]
		|-> file_rdata == $past(file_wdata, 6))
		else $error("Count moved while inhibited.");
	a_rollover_pulse: assert property (timer_rollover |=> !timer_rollover)
		else $error("Rollover longer than one clock.");
	a_wdt_direct: assert property (((!option_value[3] || option_value[2:0] == 3'h0) && !option_wr)
		|=> wdt_post_tick == $past(wdt_tick_in))
		else $error("Unscaled watchdog tick wrong.");
	a_wdt_spacing: assert property ((wdt_post_tick && option_value[3] && option_value[2:0] != 3'h0 && !option_wr)
		|=> !wdt_post_tick)
		else $error("Postscaled ticks too close.");
	a_reset_values: assert property (($past(rst) && !rst)
		|-> option_value == 8'hff && file_rdata == 8'h00 && !wdt_post_tick && !timer_rollover)
		else $error("Reset values wrong.");
endmodule

bind tmrc_top tmrc_checker u_chk (.core_clk, .rst, .external_count_input, .file_addr, .file_wr, .file_wdata,
	.option_wr, .option_wdata, .watchdog_clear_op, .wdt_tick_in, .file_rdata, .option_value, .wdt_post_tick,
	.timer_rollover, .cycle_end);

// *** dv/tmrc_pin_src.sv ***
// Purpose: External count source on the count pin.
// Assumes: Levels change just after a core_clk edge.
// Notes:   Every level is held four clocks or more.
module tmrc_pin_src (
	input  wire logic core_clk,
	output logic      pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial pin = 1'b0;

	task automatic hold(input logic v, input int n);
		@(posedge core_clk);
		pin <= v;
		repeat (n - 1) @(posedge core_clk);
	endtask

	task automatic pulses(input int n);
		repeat (n)
		begin
			hold(1'b1, 4);
			hold(1'b0, 4);
		end
	endtask
endmodule

// *** dv/tmrc_tb.sv ***
// Purpose: Self-checking bench for the timer/counter.
// Assumes: Design outputs settle before the falling edge.
// Notes:   Expected values queue up and are checked at the falling edge.
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       core_clk, rst, file_wr, option_wr, watchdog_clear_op, wdt_tick_in, chk, pclr, pin;
	logic       wdt_post_tick, timer_rollover, cycle_end;
	logic [4:0] file_addr;
	logic [7:0] file_wdata, option_wdata, file_rdata, option_value, d, posts;
	logic [9:0] exp_q[$];
	int         miscompares, cmp_count, cyc, seed;

	tmrc_top DUT (.core_clk, .rst, .external_count_input(pin), .file_addr, .file_wr, .file_wdata, .option_wr,
		.option_wdata, .watchdog_clear_op, .wdt_tick_in, .file_rdata, .option_value, .wdt_post_tick,
		.timer_rollover, .cycle_end);
	tmrc_pin_src src (.core_clk, .pin);

	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d.", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] expv);
		cmp_count++;
		if (seen !== expv)
		begin
			miscompares++;
			$display("Error at %0t: saw %h, expected %h.", $time, seen, expv);
		end
	endtask

	// ----
	// Comparison side and cycle limit.
	// ----
	always @(negedge core_clk)
		if (chk === 1'b1)
		begin
			logic [9:0] e;
			e = exp_q.pop_front();
			check(e[9] ? option_value : (e[8] ? posts : file_rdata), e[7:0]);
		end

	always @(posedge core_clk)
	begin
		posts <= pclr ? 8'h00 : posts + {7'h00, wdt_post_tick === 1'b1};
		cyc++;
		if (cyc == 30000)
		begin
			miscompares++;
			give_verdict();
		end
	end

	// ----
	// Driving side.
	// ----
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic rd(input logic [1:0] k, input logic [7:0] v);
		@(posedge core_clk);
		exp_q.push_back({k, v});
		chk <= 1'b1;
		@(posedge core_clk);
		chk <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] v);
		@(posedge core_clk);
		file_wr <= 1'b1;
		file_wdata <= v;
		@(posedge core_clk);
		file_wr <= 1'b0;
	endtask

	task automatic opt(input logic [7:0] v);
		@(posedge core_clk);
		option_wr <= 1'b1;
		option_wdata <= v;
		@(posedge core_clk);
		option_wr <= 1'b0;
	endtask

	task automatic wdc;
		@(posedge core_clk);
		watchdog_clear_op <= 1'b1;
		@(posedge core_clk);
		watchdog_clear_op <= 1'b0;
	endtask

	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge core_clk);
			wdt_tick_in <= 1'b1;
			@(posedge core_clk);
			wdt_tick_in <= 1'b0;
		end
	endtask

	task automatic to_wdt(input logic [7:0] v);
		wdc();
		wr(8'h00);
		opt(v | 8'h07);
		wdc();
		opt(v);
	endtask

	task automatic to_tmr(input logic [7:0] v);
		wdc();
		opt(v);
	endtask

	initial
	begin
		seed = 32'h7171;
		{rst, file_wr, option_wr, watchdog_clear_op, wdt_tick_in, chk, pclr} = 7'h40;
		file_addr = 5'h03;
		file_wdata = 8'h00;
		option_wdata = 8'h00;
		idle(5);
		rst <= 1'b0;
		rd(2'd2, 8'hff);
		rd(2'd0, 8'h00);
		file_addr <= 5'h01;
		for (int s = 0; s < 2; s++)
		begin
			opt({3'b001, s[0], 4'h8});
			idle(12);
			d = 8'($random(seed));
			wr(d);
			idle(12);
			src.hold(1'b1, 12);
			rd(2'd0, d + {7'h00, s == 0});
			src.hold(1'b0, 12);
			rd(2'd0, d + 8'h01);
		end
		opt(8'h08);
		for (int t = 0; t < 2; t++)
		begin
			d = t ? 8'hfe : 8'($random(seed));
			do @(negedge core_clk); while (cycle_end !== 1'b1);
			wr(d);
			idle(8);
			rd(2'd0, d);
			for (int k = 1; k < 5; k++)
			begin
				idle(2);
				rd(2'd0, d + 8'(k));
			end
		end
		for (int r = 0; r < 8; r++)
		begin
			to_tmr({5'b00100, r[2:0]});
			src.pulses(1 << r);
			d = 8'($random(seed));
			wr(d);
			idle(12);
			src.pulses(1 << r);
			idle(12);
			rd(2'd0, d + 8'h01);
			src.pulses(2 << r);
			idle(12);
			rd(2'd0, d + 8'h02);
		end
		for (int n = 0; n < 8; n++)
		begin
			to_wdt({5'b00001, n[2:0]});
			tick(n ? 1 << (n - 1) : 1);
			wdc();
			pclr <= 1'b1;
			@(posedge core_clk);
			pclr <= 1'b0;
			tick(n ? 3 << (n - 1) : 3);
			idle(3);
			rd(2'd1, n ? 8'h02 : 8'h03);
		end
		idle(4);
		give_verdict();
	end
endmodule

// *** logic/tmrc_map.vh ***
// Purpose: Constants for the timer/counter with shared prescaler.
// Assumes: Core clock of 20 MHz, four clocks to one instruction cycle.
// Notes:   Included by its bare name by every design file.
`ifndef TMRC_MAP_VH
`define TMRC_MAP_VH

// ----------------------------------------------------------------
// Register addresses and reset values
// ----------------------------------------------------------------
`define TMRC_TIMER_COUNT_ADDR   5'h01
`define TMRC_OPTION_RESET       8'hff
`define TMRC_READ_ZERO          8'h00

// ----------------------------------------------------------------
// Option control field positions
// ----------------------------------------------------------------
`define TMRC_CLOCK_SOURCE_BIT   5
`define TMRC_SOURCE_EDGE_BIT    4
`define TMRC_PRESCALER_ASSIGN_BIT 3
`define TMRC_PRESCALE_RATE_MSB  2
`define TMRC_PRESCALE_RATE_LSB  0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TMRC_CLK_PERIOD_NS      50
`define TMRC_CLKS_PER_CYCLE     4
`define TMRC_PHASE_Q1           2'h0
`define TMRC_PHASE_Q2           2'h1
`define TMRC_PHASE_Q3           2'h2
`define TMRC_PHASE_Q4           2'h3
`define TMRC_INHIBIT_CYCLES     2'h2
`define TMRC_PRESCALER_WIDTH    8

`endif

// *** logic/tmrc_prescaler.v ***
// Purpose: Eight-bit shared prescaler counter.
// Assumes: The count enable is a one-clock pulse on core_clk.
// Notes:   The counter value never leaves the block towards software.
`include "tmrc_map.vh"

module tmrc_prescaler (
	input  wire       core_clk,
	input  wire       rst,
	input  wire       clear,
	input  wire       count_en,
	output reg  [7:0] count_q
);

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	reg [7:0] count_d;

	always @*
	begin
		count_d = count_q;
		if (clear)
		begin
			count_d = 8'h00;
		end
		else if (count_en)
		begin
			count_d = count_q + 8'h01;
		end
	end

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			count_q <= 8'h00;
		end
		else
		begin
			count_q <= count_d;
		end
	end

endmodule

// *** logic/tmrc_sync.v ***
// Purpose: Three-flop synchroniser for the external count pin.
// Assumes: The pin is asynchronous to core_clk.
// Notes:   The output only moves once the second and third flops agree.
`include "tmrc_map.vh"

module tmrc_sync (
	input  wire core_clk,
	input  wire rst,
	input  wire pin_in,
	output reg  level_q
);

	// ----------------------------------------------------------------
	// Synchroniser chain
	// ----------------------------------------------------------------
	reg meta_q;
	reg stage2_q;
	reg stage3_q;

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			meta_q   <= 1'b0;
			stage2_q <= 1'b0;
			stage3_q <= 1'b0;
			level_q  <= 1'b0;
		end
		else
		begin
			meta_q   <= pin_in;
			stage2_q <= meta_q;
			stage3_q <= stage2_q;
			if (stage2_q == stage3_q)
			begin
				level_q <= stage3_q;
			end
		end
	end

endmodule

// *** logic/tmrc_top.v ***
// Purpose: Eight-bit timer/counter with a prescaler shared with the watchdog.
// Assumes: Core writes are one-clock strobes; the watchdog lives outside.
// Notes:   Quarter phases are made here from core_clk, Q1 first after reset.
`include "tmrc_map.vh"

//
// Summary of operation
// - Source select clear: count instruction cycles.
// - Count write inhibits increments two cycles.
// - Source select set: count external pin edges.
// - Edge select: clear rising, set falling.
// - Prescaler serves timer or watchdog, never both.
// - Timer prescale ratios span 1:2 to 1:256.
// - Prescaler value is never readable or writable.
// - Prescaler output sampled on Q2 and Q4.
// - External input divided before synchronisation sampling when timer owns the prescaler.
// - Count increments after the sampling stage, or straight on Q4 when source select is clear and the watchdog owns the prescaler.
// - Eight-bit prescaler, or watchdog postscaler.
// - Count writes clear prescaler when timer owns it.
// - Watchdog clear clears prescaler when watchdog owns.
// - Reset clears every prescaler bit.
// - Read/write count register at address 01h.
module tmrc_top (
	input  wire       core_clk,
	input  wire       rst,
	input  wire       external_count_input,
	input  wire [4:0] file_addr,
	input  wire       file_wr,
	input  wire [7:0] file_wdata,
	input  wire       option_wr,
	input  wire [7:0] option_wdata,
	input  wire       watchdog_clear_op,
	input  wire       wdt_tick_in,
	output reg  [7:0] file_rdata,
	output reg  [7:0] option_value,
	output reg        wdt_post_tick,
	output reg        timer_rollover,
	output reg        cycle_end
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function tmrc_tap;
		input [7:0] cnt;
		input [2:0] idx;
		begin
			tmrc_tap = cnt[idx];
		end
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	reg  [1:0] phase_q;
	reg  [1:0] phase_d;
	reg  [7:0] timer_count_q;
	reg  [7:0] timer_count_d;
	reg  [1:0] inhibit_q;
	reg  [1:0] inhibit_d;
	reg        ext_sel_q;
	reg        sample_q;
	reg        sample_d;
	reg        rise_q;
	reg        rise_d;
	reg        wdt_tap_q;
	reg        wdt_post_d;
	reg        inc_evt;
	reg        presc_src;
	reg        presc_in;
	reg        rollover_d;
	reg  [7:0] rdata_d;

	wire       ext_level;
	wire [7:0] presc_count;
	wire       clock_source_select;
	wire       source_edge_select;
	wire       prescaler_assign;
	wire [2:0] prescale_rate;
	wire       phase_q2;
	wire       phase_q4;
	wire       sample_strobe;
	wire       count_hit;
	wire       count_write;
	wire       presc_clear;
	wire       ext_sel;
	wire       ext_edge;
	wire       timer_tap;
	wire       wdt_tap;
	wire [2:0] wdt_idx;

	// ----------------------------------------------------------------
	// Option fields
	// ----------------------------------------------------------------
	assign clock_source_select = option_value[`TMRC_CLOCK_SOURCE_BIT];
	assign source_edge_select  = option_value[`TMRC_SOURCE_EDGE_BIT];
	assign prescaler_assign    = option_value[`TMRC_PRESCALER_ASSIGN_BIT];
	assign prescale_rate       = option_value[`TMRC_PRESCALE_RATE_MSB:`TMRC_PRESCALE_RATE_LSB];

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			option_value <= `TMRC_OPTION_RESET;
		end
		else if (option_wr)
		begin
			option_value <= option_wdata;
		end
	end

	// ----------------------------------------------------------------
	// Quarter phases
	// ----------------------------------------------------------------
	assign phase_q2      = (phase_q == `TMRC_PHASE_Q2);
	assign phase_q4      = (phase_q == `TMRC_PHASE_Q4);
	assign sample_strobe = phase_q2 | phase_q4;

	always @*
	begin
		phase_d = phase_q + 2'h1;
	end

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			phase_q   <= `TMRC_PHASE_Q1;
			cycle_end <= 1'b0;
		end
		else
		begin
			phase_q   <= phase_d;
			cycle_end <= (phase_d == `TMRC_PHASE_Q4);
		end
	end

	// ----------------------------------------------------------------
	// External input and edge select
	// ----------------------------------------------------------------
	tmrc_sync u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.pin_in   (external_count_input),
		.level_q  (ext_level)
	);

	assign ext_sel  = ext_level ^ source_edge_select;
	assign ext_edge = ext_sel & ~ext_sel_q;

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			ext_sel_q <= 1'b0;
		end
		else
		begin
			ext_sel_q <= ext_sel;
		end
	end

	// ----------------------------------------------------------------
	// Shared prescaler
	// ----------------------------------------------------------------
	assign count_hit   = (file_addr == `TMRC_TIMER_COUNT_ADDR);
	assign count_write = file_wr & count_hit;
	assign presc_clear = (count_write & ~prescaler_assign) |
		(watchdog_clear_op & prescaler_assign);

	always @*
	begin
		presc_in = 1'b0;
		if (prescaler_assign)
		begin
			presc_in = wdt_tick_in;
		end
		else if (clock_source_select)
		begin
			presc_in = ext_edge;
		end
		else
		begin
			presc_in = phase_q4;
		end
	end

	tmrc_prescaler u_prescaler (
		.core_clk (core_clk),
		.rst      (rst),
		.clear    (presc_clear),
		.count_en (presc_in),
		.count_q  (presc_count)
	);

	assign timer_tap = tmrc_tap(presc_count, prescale_rate);
	assign wdt_idx   = prescale_rate - 3'h1;
	assign wdt_tap   = tmrc_tap(presc_count, wdt_idx);

	// ----------------------------------------------------------------
	// Watchdog postscaler output
	// ----------------------------------------------------------------
	always @*
	begin
		wdt_post_d = wdt_tick_in;
		if (prescaler_assign && (prescale_rate != 3'h0))
		begin
			wdt_post_d = wdt_tap & ~wdt_tap_q;
		end
	end

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			wdt_tap_q     <= 1'b0;
			wdt_post_tick <= 1'b0;
		end
		else
		begin
			wdt_tap_q     <= wdt_tap;
			wdt_post_tick <= wdt_post_d;
		end
	end

	// ----------------------------------------------------------------
	// Sampling of the prescaler output
	// ----------------------------------------------------------------
	always @*
	begin
		if (prescaler_assign)
		begin
			presc_src = ext_sel;
		end
		else
		begin
			presc_src = timer_tap;
		end
		sample_d = sample_q;
		rise_d   = 1'b0;
		if (sample_strobe)
		begin
			sample_d = presc_src;
			rise_d   = presc_src & ~sample_q;
		end
	end

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			sample_q <= 1'b0;
			rise_q   <= 1'b0;
		end
		else
		begin
			sample_q <= sample_d;
			rise_q   <= rise_d;
		end
	end

	// ----------------------------------------------------------------
	// Increment source
	// ----------------------------------------------------------------
	always @*
	begin
		if (!clock_source_select && prescaler_assign)
		begin
			inc_evt = phase_q4;
		end
		else
		begin
			inc_evt = rise_q;
		end
	end

	// ----------------------------------------------------------------
	// Write inhibit
	// ----------------------------------------------------------------
	always @*
	begin
		inhibit_d = inhibit_q;
		if (count_write)
		begin
			inhibit_d = `TMRC_INHIBIT_CYCLES;
		end
		else if (phase_q4 && (inhibit_q != 2'h0))
		begin
			inhibit_d = inhibit_q - 2'h1;
		end
	end

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			inhibit_q <= 2'h0;
		end
		else
		begin
			inhibit_q <= inhibit_d;
		end
	end

	// ----------------------------------------------------------------
	// Count register
	// ----------------------------------------------------------------
	always @*
	begin
		timer_count_d = timer_count_q;
		rollover_d    = 1'b0;
		if (count_write)
		begin
			timer_count_d = file_wdata;
		end
		else if (inc_evt && (inhibit_q == 2'h0))
		begin
			timer_count_d = timer_count_q + 8'h01;
			rollover_d    = (timer_count_q == 8'hff);
		end
	end

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			timer_count_q  <= 8'h00;
			timer_rollover <= 1'b0;
		end
		else
		begin
			timer_count_q  <= timer_count_d;
			timer_rollover <= rollover_d;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always @*
	begin
		rdata_d = `TMRC_READ_ZERO;
		if (count_hit)
		begin
			rdata_d = timer_count_q;
		end
	end

	always @(posedge core_clk)
	begin
		if (rst)
		begin
			file_rdata <= `TMRC_READ_ZERO;
		end
		else
		begin
			file_rdata <= rdata_d;
		end
	end

endmodule
